// ### design/roc_regulator_output_config_regs.sv
// Purpose : buck off-state selects and three linear-regulator level registers
// Assumes : serial slave engine presents byte address, data and one-cycle strobes
// Notes   : reset values of the off-select byte and the level code fields are the factory option inputs, sampled during reset
`timescale 1ns/1ps
`include "roc_defs.svh"

module roc_regulator_output_config_regs
   import roc_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire logic      nrst,
   input  wire roc_byte_t reg_addr,
   input  wire roc_byte_t reg_wdata,
   input  wire logic      reg_wr,
   input  wire logic      reg_rd,
   output roc_byte_t      reg_rdata,
   input  wire roc_byte_t opt_buck_mode,
   input  wire roc_code_t opt_linreg1_code,
   input  wire roc_code_t opt_linreg2_code,
   input  wire roc_code_t opt_linreg3_code,
   output logic           conv1_off_discharge_sel,
   output logic           conv2_off_discharge_sel,
   output logic           conv3_off_discharge_sel,
   output logic           conv4_off_discharge_sel,
   output roc_code_t      linreg1_level_code,
   output roc_code_t      linreg2_level_code,
   output roc_code_t      linreg3_level_code,
   output roc_mv_t        linreg1_mv,
   output roc_mv_t        linreg2_mv,
   output roc_mv_t        linreg3_mv
);

   // ************************************************************
   // storage
   // ************************************************************
   roc_byte_t buck_off_state_select_ff;
   roc_byte_t ldo_level_ff [`ROC_NUM_LDO];
   roc_mv_t   ldo_mv_ff    [`ROC_NUM_LDO];
   roc_byte_t reg_rdata_ff;
   roc_code_t opt_code     [`ROC_NUM_LDO];
   roc_byte_t ldo_ofs      [`ROC_NUM_LDO];

   assign opt_code[0] = opt_linreg1_code;
   assign opt_code[1] = opt_linreg2_code;
   assign opt_code[2] = opt_linreg3_code;
   assign ldo_ofs[0]  = `ROC_OFS_LDO_ONE;
   assign ldo_ofs[1]  = `ROC_OFS_LDO_TWO;
   assign ldo_ofs[2]  = `ROC_OFS_LDO_THREE;

   // saturating code to millivolt conversion
   function automatic roc_mv_t code_to_mv(input roc_code_t code);
      roc_mv_t prod;
      prod = 12'(`ROC_LDO_STEP_MV * {5'h00, code});
      if (code >= `ROC_LDO_SAT_CODE) begin
         code_to_mv = `ROC_LDO_MAX_MV;
      end else begin
         code_to_mv = 12'(`ROC_LDO_MIN_MV + prod);
      end
   endfunction

   // ************************************************************
   // buck off-state register; mode bits above are kept as plain storage
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         buck_off_state_select_ff <= opt_buck_mode;
      end else if (reg_wr && reg_addr == `ROC_OFS_BUCK_OFF_SEL) begin
         buck_off_state_select_ff <= reg_wdata;
      end
   end

   // ************************************************************
   // linear regulator level registers
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `ROC_NUM_LDO; gi++) begin : g_ldo
         always_ff @(posedge ref_clk) begin
            if (!nrst) begin
               ldo_level_ff[gi] <= {`ROC_RSVD_RESET, opt_code[gi]};
            end else if (reg_wr && reg_addr == ldo_ofs[gi]) begin
               ldo_level_ff[gi] <= reg_wdata;
            end
         end

         // one cycle behind the code; analog side sees a settled value anyway
         always_ff @(posedge ref_clk) begin
            if (!nrst) begin
               ldo_mv_ff[gi] <= `ROC_LDO_MIN_MV;
            end else begin
               ldo_mv_ff[gi] <= code_to_mv(ldo_level_ff[gi][`ROC_CODE_MSB:0]);
            end
         end

         property p_ldo_write;
            @(posedge ref_clk) disable iff (!nrst)
            reg_wr && reg_addr == ldo_ofs[gi] |=> ldo_level_ff[gi] == $past(reg_wdata);
         endproperty
         a_ldo_write: assert property (p_ldo_write)
            else $error("level register did not take the write");

         property p_ldo_hold;
            @(posedge ref_clk) disable iff (!nrst)
            !(reg_wr && reg_addr == ldo_ofs[gi]) |=> $stable(ldo_level_ff[gi]);
         endproperty
         a_ldo_hold: assert property (p_ldo_hold)
            else $error("level register moved without a write");

         // millivolts lag the code by one cycle and show the minimum during reset,
         // so the first edge after a release carries no converted value yet
         property p_mv_linear;
            @(posedge ref_clk) disable iff (!nrst)
            $past(nrst) && $past(ldo_level_ff[gi][6:0]) < 7'h50 |-> ldo_mv_ff[gi] ==
               12'(12'h640 + 12'h019 * {5'h00, $past(ldo_level_ff[gi][6:0])});
         endproperty
         a_mv_linear: assert property (p_mv_linear)
            else $error("millivolt value off the linear map");

         property p_mv_sat;
            @(posedge ref_clk) disable iff (!nrst)
            $past(nrst) && $past(ldo_level_ff[gi][6:0]) >= 7'h50 |-> ldo_mv_ff[gi] == 12'hE10;
         endproperty
         a_mv_sat: assert property (p_mv_sat)
            else $error("high code did not saturate at maximum");
      end
   endgenerate

   // ************************************************************
   // read path: registered, unmapped offsets read zero
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rdata_ff <= `ROC_UNMAPPED_READ;
      end else if (reg_rd) begin
         case (reg_addr)
            `ROC_OFS_BUCK_OFF_SEL: reg_rdata_ff <= buck_off_state_select_ff;
            `ROC_OFS_LDO_ONE:      reg_rdata_ff <= ldo_level_ff[0];
            `ROC_OFS_LDO_TWO:      reg_rdata_ff <= ldo_level_ff[1];
            `ROC_OFS_LDO_THREE:    reg_rdata_ff <= ldo_level_ff[2];
            default:               reg_rdata_ff <= `ROC_UNMAPPED_READ;
         endcase
      end
   end

   // ************************************************************
   // outputs, all straight from flops
   // ************************************************************
   assign reg_rdata               = reg_rdata_ff;
   assign conv1_off_discharge_sel = buck_off_state_select_ff[`ROC_CONV1_OFF_BIT];
   assign conv2_off_discharge_sel = buck_off_state_select_ff[`ROC_CONV1_OFF_BIT - 1];
   assign conv3_off_discharge_sel = buck_off_state_select_ff[`ROC_CONV1_OFF_BIT - 2];
   assign conv4_off_discharge_sel = buck_off_state_select_ff[`ROC_CONV4_OFF_BIT];
   assign linreg1_level_code      = ldo_level_ff[0][`ROC_CODE_MSB:0];
   assign linreg2_level_code      = ldo_level_ff[1][`ROC_CODE_MSB:0];
   assign linreg3_level_code      = ldo_level_ff[2][`ROC_CODE_MSB:0];
   assign linreg1_mv              = ldo_mv_ff[0];
   assign linreg2_mv              = ldo_mv_ff[1];
   assign linreg3_mv              = ldo_mv_ff[2];

   // ************************************************************
   // checks
   // ************************************************************
   property p_off_sel;
      @(posedge ref_clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h06 |=> {conv1_off_discharge_sel, conv2_off_discharge_sel,
         conv3_off_discharge_sel, conv4_off_discharge_sel} == $past(reg_wdata[3:0]);
   endproperty
   a_off_sel: assert property (p_off_sel) else $error("off select bits wrong");

   property p_rd_two;
      @(posedge ref_clk) disable iff (!nrst)
      reg_rd && reg_addr == 8'h08 && !reg_wr |=> reg_rdata == ldo_level_ff[1];
   endproperty
   a_rd_two: assert property (p_rd_two) else $error("offset 08 read wrong");

   property p_rd_one;
      @(posedge ref_clk) disable iff (!nrst)
      reg_rd && reg_addr == 8'h07 |=> reg_rdata == $past(ldo_level_ff[0]);
   endproperty
   a_rd_one: assert property (p_rd_one) else $error("offset 07 read wrong");

   // mode bits share this byte, so a stray write would move the off selects as well
   property p_buck_hold;
      @(posedge ref_clk) disable iff (!nrst)
      !(reg_wr && reg_addr == 8'h06) |=> $stable(buck_off_state_select_ff);
   endproperty
   a_buck_hold: assert property (p_buck_hold)
      else $error("off select byte moved without a write");

   property p_rd_three;
      @(posedge ref_clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h09 ##1 reg_rd && reg_addr == 8'h09 && !reg_wr
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_rd_three: assert property (p_rd_three) else $error("offset 09 readback wrong");

   property p_reset_load;
      @(posedge ref_clk)
      !nrst |=> linreg1_level_code == $past(opt_linreg1_code) && ldo_level_ff[0][7] == 1'b0
         && linreg3_level_code == $past(opt_linreg3_code)
         && conv1_off_discharge_sel == $past(opt_buck_mode[3]);
   endproperty
   a_reset_load: assert property (p_reset_load) else $error("reset did not load options");

   property p_unmapped;
      @(posedge ref_clk) disable iff (!nrst)
      reg_rd && (reg_addr < 8'h06 || reg_addr > 8'h09) |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   c_wr_ldo1: cover property (@(posedge ref_clk) disable iff (!nrst)
      reg_wr && reg_addr == 8'h07);
   c_sat: cover property (@(posedge ref_clk) disable iff (!nrst)
      linreg2_level_code == 7'h7F ##1 linreg2_mv == 12'hE10);
   c_discharge: cover property (@(posedge ref_clk) disable iff (!nrst)
      $rose(conv4_off_discharge_sel));
   c_readback: cover property (@(posedge ref_clk) disable iff (!nrst)
      reg_rd && reg_addr == 8'h06 ##1 reg_rdata != 8'h00);

endmodule

// ### design/roc_defs.svh
// Purpose : offsets, field positions and figures for the regulator output config bank
// Assumes : byte-wide registers behind the serial slave's internal port
// Notes   : definitions only
`ifndef ROC_DEFS_SVH
`define ROC_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define ROC_OFS_BUCK_OFF_SEL   8'h06
`define ROC_OFS_LDO_ONE        8'h07
`define ROC_OFS_LDO_TWO        8'h08
`define ROC_OFS_LDO_THREE      8'h09

// ************************************************************
// fields
// ************************************************************
`define ROC_CONV1_OFF_BIT      3
`define ROC_CONV4_OFF_BIT      0
`define ROC_CODE_MSB           6
`define ROC_RSVD_BIT           7
`define ROC_RSVD_RESET         1'h0
`define ROC_UNMAPPED_READ      8'h00

// ************************************************************
// level code to millivolt mapping
// ************************************************************
`define ROC_LDO_MIN_MV         12'h640
`define ROC_LDO_STEP_MV        12'h019
`define ROC_LDO_MAX_MV         12'hE10
`define ROC_LDO_SAT_CODE       7'h50
`define ROC_NUM_LDO            3

`endif

// ### design/roc_pkg.sv
// Purpose : shared types of the regulator output config bank
// Assumes : constants live in roc_defs.svh
// Notes   : none
package roc_pkg;
   typedef logic [6:0]  roc_code_t;
   typedef logic [11:0] roc_mv_t;
   typedef logic [7:0]  roc_byte_t;
endpackage

// ### test/roc_host_model.sv
// Purpose : host side of the register port, issuing single-byte reads and writes
// Assumes : strobes are taken on the rising edge, read data is valid one cycle later
// Notes   : address and data are inverted when idle so stale values never look valid
`timescale 1ns/1ps
module roc_host_model
   import roc_pkg::*;
(
   input  wire logic      ref_clk,
   input  wire roc_byte_t reg_rdata,
   output roc_byte_t      reg_addr,
   output roc_byte_t      reg_wdata,
   output logic           reg_wr,
   output logic           reg_rd
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   task automatic wr_reg(input roc_byte_t a, input roc_byte_t d);
      @(posedge ref_clk) #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge ref_clk) #1;
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask

   // write then read the same offset on the very next edge
   task automatic wr_rd_reg(input roc_byte_t a, input roc_byte_t d, output roc_byte_t q);
      @(posedge ref_clk) #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge ref_clk) #1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b1;
      reg_wdata = ~d;
      @(posedge ref_clk) #1;
      reg_rd    = 1'b0;
      reg_addr  = ~a;
      q         = reg_rdata;
   endtask

   task automatic rd_reg(input roc_byte_t a, output roc_byte_t d);
      @(posedge ref_clk) #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge ref_clk) #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask
endmodule

// ### test/regulator_output_config_regs_tb.sv
// Purpose : self-checking bench for the regulator output config bank
// Assumes : 200 MHz clock, synchronous active-low reset
// Notes   : expectations are worked out here from the level mapping
`timescale 1ns/1ps
module regulator_output_config_regs_tb
   import roc_pkg::*;
;
   logic      ref_clk;
   logic      nrst;
   roc_byte_t reg_addr, reg_wdata, reg_rdata, rd;
   logic      reg_wr, reg_rd;
   logic      c1, c2, c3, c4;
   roc_code_t lc [3];
   roc_mv_t   mv [3];
   roc_code_t opt [3] = '{7'h12, 7'h50, 7'h7F};
   roc_byte_t wd [3]  = '{8'hCF, 8'h00, 8'h50};
   roc_byte_t obm     = 8'hA5;
   int        bad_count = 0;
   int        num_checks = 0;

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   roc_host_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

   roc_regulator_output_config_regs dut (.ref_clk(ref_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .opt_buck_mode(obm), .opt_linreg1_code(opt[0]),
      .opt_linreg2_code(opt[1]), .opt_linreg3_code(opt[2]),
      .conv1_off_discharge_sel(c1), .conv2_off_discharge_sel(c2),
      .conv3_off_discharge_sel(c3), .conv4_off_discharge_sel(c4),
      .linreg1_level_code(lc[0]), .linreg2_level_code(lc[1]), .linreg3_level_code(lc[2]),
      .linreg1_mv(mv[0]), .linreg2_mv(mv[1]), .linreg3_mv(mv[2]));

   // saturation above the top code keeps the maximum at 3.6 V
   function automatic roc_mv_t exp_mv(input roc_code_t c);
      return (c >= 7'h50) ? 12'hE10 : 12'h640 + 12'h019 * {5'h00, c};
   endfunction

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #20000;
      bad_count++;
      end_of_test();
   end

   initial begin
      nrst = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 check({c1, c2, c3, c4}, 4'h5);
      host.rd_reg(8'h06, rd);
      check(rd, 8'hA5);
      for (int i = 0; i < 3; i++) begin
         check(lc[i], opt[i]);
         check(mv[i], exp_mv(opt[i]));
         host.rd_reg(8'h07 + i[7:0], rd);
         check(rd, {1'b0, opt[i]});
      end
      for (int i = 0; i < 3; i++) begin
         host.wr_reg(8'h07 + i[7:0], wd[i]);
         @(posedge ref_clk) #1;
         check(lc[i], wd[i][6:0]);
         check(mv[i], exp_mv(wd[i][6:0]));
         host.rd_reg(8'h07 + i[7:0], rd);
         check(rd, wd[i]);
      end
      check(mv[0], 12'hDF7);
      check(mv[1], 12'h640);
      check(mv[2], 12'hE10);
      host.wr_reg(8'h06, 8'h0A);
      check({c1, c2, c3, c4}, 4'hA);
      host.wr_reg(8'h06, 8'h05);
      check({c1, c2, c3, c4}, 4'h5);
      host.wr_reg(8'h0A, 8'hFF);
      host.rd_reg(8'h0A, rd);
      check(rd, 8'h00);
      host.rd_reg(8'h07, rd);
      check(rd, 8'hCF);
      host.wr_rd_reg(8'h09, 8'h33, rd);
      check(rd, 8'h33);
      check(lc[2], 7'h33);
      check(mv[2], 12'hB3B);
      // second reset in mid-run with new factory options
      nrst = 1'b0;
      obm  = 8'h3C;
      opt  = '{7'h2A, 7'h7F, 7'h4F};
      repeat (2) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 check({c1, c2, c3, c4}, 4'hC);
      for (int i = 0; i < 3; i++) begin
         check(lc[i], opt[i]);
         check(mv[i], exp_mv(opt[i]));
      end
      host.rd_reg(8'h07, rd);
      check(rd, 8'h2A);
      host.rd_reg(8'h06, rd);
      check(rd, 8'h3C);
      end_of_test();
   end
endmodule
